/* core/cmpg_pkg.sv */
// Purpose: shared constants and types for the core memory parity guard
// Assumes: 24-bit data words, memory control time counted in clock steps
// Notes: sizes are in words
`default_nettype none
package cmpg_pkg;
  localparam int unsigned CMPG_DATA_W = 24;
  localparam int unsigned CMPG_ADDR_W = 15;
  localparam logic [4:0] CMPG_CHECK_TIME = 5'h0C;
  localparam logic [4:0] CMPG_LAST_TIME = 5'h1F;
  localparam logic [CMPG_ADDR_W-1:0] CMPG_SIZE_16K = 15'h4000;
  localparam logic [CMPG_ADDR_W-1:0] CMPG_SIZE_24K = 15'h6000;
  localparam int unsigned CMPG_STACK_BIT = 14;
  localparam int unsigned CMPG_USERS = 4;
  localparam logic [1:0] CMPG_USER_CPU = 2'h0;

  typedef enum logic [1:0] {CMPG_MEM_16K, CMPG_MEM_24K, CMPG_MEM_32K} cmpg_size_type;

  typedef struct packed {
    cmpg_size_type size;
    logic no_channel_req;
    logic swap_stacks;
  } cmpg_cfg_type;

  typedef struct packed {
    logic upper_read;
    logic upper_write;
    logic lower_read;
    logic lower_write;
  } cmpg_drive_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] user;
    logic [CMPG_ADDR_W-1:0] addr;
    logic [CMPG_DATA_W-1:0] data;
    logic user_parity;
  } cmpg_req_type;

  function automatic logic cmpg_odd(input logic [CMPG_DATA_W-1:0] d);
    return ^d;
  endfunction : cmpg_odd
endpackage : cmpg_pkg
`default_nettype wire

/* core/cmpg_parity_unit.sv */
// Purpose: odd-ones detect, parity generation and check compares
// Assumes: purely combinational, same clock domain as caller
// Notes: shared by the read check and the write transmission check
`default_nettype none
module cmpg_parity_unit
  import cmpg_pkg::*;
(
  input wire logic [CMPG_DATA_W-1:0] data,
  input wire logic parity_in,
  output logic data_odd_detect,
  output logic gen_parity,
  output logic odd_data_parity_one_error,
  output logic even_data_parity_zero_error,
  output logic mismatch
);
  assign data_odd_detect = cmpg_odd(data);
  assign gen_parity = ~data_odd_detect;
  assign odd_data_parity_one_error = data_odd_detect & parity_in;
  assign even_data_parity_zero_error = ~data_odd_detect & ~parity_in;
  assign mismatch = odd_data_parity_one_error | even_data_parity_zero_error;
endmodule : cmpg_parity_unit
`default_nettype wire

/* core/cmpg_addr_map.sv */
// Purpose: stack select, wrap-around and out-of-range detect
// Assumes: configuration already held steady by caller
// Notes: combinational
`default_nettype none
module cmpg_addr_map
  import cmpg_pkg::*;
(
  input wire logic [CMPG_ADDR_W-1:0] addr,
  input wire cmpg_cfg_type cfg,
  output logic [CMPG_ADDR_W-1:0] wrapped_addr,
  output logic upper_stack,
  output logic out_of_range_address
);
  wire logic in_top_half;
  assign in_top_half = addr[CMPG_STACK_BIT];
  assign wrapped_addr = (cfg.size == CMPG_MEM_16K) ?
    {1'b0, addr[CMPG_STACK_BIT-1:0]} : addr;
  assign out_of_range_address = (cfg.size == CMPG_MEM_24K) &&
    (addr >= CMPG_SIZE_24K);
  // swap only applied at the 32K size, with both stacks fully fitted
  assign upper_stack = (cfg.size == CMPG_MEM_16K) ? 1'b0 :
    (in_top_half ^ (cfg.swap_stacks && cfg.size == CMPG_MEM_32K));
endmodule : cmpg_addr_map
`default_nettype wire

/* core/cmpg_core_memory_parity_guard.sv */
// Purpose: parity check, error flags and power-loss cycle gating
// Assumes: one memory cycle per request, timed by a step counter
// Notes: initialize input acts as the reset of the error flags
`default_nettype none
module cmpg_core_memory_parity_guard
  import cmpg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire cmpg_cfg_type cfg_pins,
  input wire cmpg_req_type req,
  input wire logic [CMPG_DATA_W-1:0] sense_data,
  input wire logic sense_parity_lower,
  input wire logic sense_parity_upper,
  input wire logic jump_if_no_parity,
  input wire logic clear_alarm,
  input wire logic initialize,
  input wire logic stop_on_parity,
  input wire logic alarm_option,
  input wire logic temp_out_of_range_pin,
  input wire logic power_loss_init_signal,
  input wire logic power_loss_start_block_signal,
  input wire logic power_loss_drive_block_signal,
  output logic req_accept,
  output logic parity_error_flag,
  output logic console_parity_lamp_flag,
  output logic core_parity_lamp,
  output logic core_temp_lamp,
  output logic alarm_lamp,
  output logic external_alarm,
  output logic no_parity_error,
  output logic cpu_access_blocked,
  output logic memory_halted,
  output logic [CMPG_USERS-1:0] channel_error_lamp,
  output logic [CMPG_USERS-1:0] user_parity_error_out,
  output logic [CMPG_USERS-1:0] transmission_parity_error,
  output logic cycle_initiate_flag,
  output logic memory_busy_flag,
  output logic initialize_flag,
  output logic [CMPG_ADDR_W-1:0] mem_addr,
  output logic [CMPG_DATA_W-1:0] write_data,
  output logic write_parity,
  output logic [CMPG_DATA_W-1:0] read_data,
  output cmpg_drive_type drive
);
  // two-flop synchronisers for pins
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  wire logic mon_a;
  wire logic mon_b;
  wire logic mon_c;
  wire logic temp_bad;
  wire logic stop_sw;
  assign mon_a = sync2_q[0];
  assign mon_b = sync2_q[1];
  assign mon_c = sync2_q[2];
  assign temp_bad = sync2_q[3];
  assign stop_sw = sync2_q[4];
  cmpg_cfg_type cfg_q;
  cmpg_req_type cur_q;
  logic [4:0] step_q;
  logic upper_q;
  logic oor_q;
  logic perr_q;
  logic lamp_q;
  logic halt_q;
  logic [CMPG_USERS-1:0] chan_lamp_q;
  logic [CMPG_USERS-1:0] user_err_q;
  logic [CMPG_USERS-1:0] tx_err_q;
  logic [CMPG_DATA_W-1:0] data_q;
  logic par_q;
  logic [CMPG_ADDR_W-1:0] addr_q;
  wire logic [CMPG_ADDR_W-1:0] wrapped_addr;
  wire logic upper_stack;
  wire logic out_of_range_address;
  cmpg_addr_map u_map (
    .addr(req.addr),
    .cfg(cfg_q),
    .wrapped_addr(wrapped_addr),
    .upper_stack(upper_stack),
    .out_of_range_address(out_of_range_address)
  );

  // read check: parity bit from addressed stack, forced one beyond range
  wire logic parity_bit_select;
  assign parity_bit_select = oor_q | (upper_q ? sense_parity_upper :
    sense_parity_lower);
  wire logic odd_data_parity_one_error;
  wire logic even_data_parity_zero_error;
  wire logic rd_err;
  cmpg_parity_unit u_rd (
    .data(sense_data),
    .parity_in(parity_bit_select),
    .data_odd_detect(),
    .gen_parity(),
    .odd_data_parity_one_error(odd_data_parity_one_error),
    .even_data_parity_zero_error(even_data_parity_zero_error),
    .mismatch(rd_err)
  );

  // write side: generated bit stored, user bit only compared
  wire logic data_odd_detect;
  wire logic wr_gen;
  wire logic transmission_parity_compare;
  cmpg_parity_unit u_wr (
    .data(req.data),
    .parity_in(req.user_parity),
    .data_odd_detect(data_odd_detect),
    .gen_parity(wr_gen),
    .odd_data_parity_one_error(),
    .even_data_parity_zero_error(),
    .mismatch(transmission_parity_compare)
  );

  wire logic busy;
  wire logic is_cpu;
  wire logic req_allowed;
  wire logic initiate_from_request;
  wire logic check_now;
  wire logic clr_main;
  wire logic clr_lamp;
  wire logic tx_err_now;
  wire logic [CMPG_USERS-1:0] cur_user_onehot;
  wire logic [CMPG_USERS-1:0] req_user_onehot;
  assign busy = memory_busy_flag;
  assign is_cpu = (req.user == CMPG_USER_CPU);
  assign req_allowed = req.valid & (is_cpu ? ~cpu_access_blocked : ~cfg_q.no_channel_req)
    & ~halt_q;
  // any monitor low blocks a start; running cycles finish unless the first monitor drops, which ends them at once
  assign initiate_from_request = req_allowed & ~busy & mon_a & mon_b & mon_c
    & ~initialize_flag;
  assign req_accept = initiate_from_request;
  assign check_now = busy & ~cur_q.write & (step_q == CMPG_CHECK_TIME);
  assign clr_main = jump_if_no_parity | clear_alarm | initialize;
  assign clr_lamp = clear_alarm | initialize;
  assign cur_user_onehot = CMPG_USERS'(1) << cur_q.user;
  assign req_user_onehot = CMPG_USERS'(1) << req.user;
  assign tx_err_now = initiate_from_request & req.write & ~is_cpu
    & transmission_parity_compare;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else if (clk_en)
    begin
      sync1_q <= {stop_on_parity, temp_out_of_range_pin, power_loss_drive_block_signal,
        power_loss_start_block_signal, power_loss_init_signal};
      sync2_q <= sync1_q;
    end
  end

  // cycle sequencer
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      cfg_q <= '{size: CMPG_MEM_16K, no_channel_req: 1'b0, swap_stacks: 1'b0};
      cur_q <= '0;
      step_q <= '0;
      upper_q <= 1'b0;
      oor_q <= 1'b0;
      cycle_initiate_flag <= 1'b0;
      memory_busy_flag <= 1'b0;
      initialize_flag <= 1'b1;
      addr_q <= '0;
      data_q <= '0;
      par_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!busy)
        cfg_q <= cfg_pins;
      cycle_initiate_flag <= initiate_from_request;
      if (!mon_a)
      begin
        cycle_initiate_flag <= 1'b0;
        memory_busy_flag <= 1'b0;
        initialize_flag <= 1'b1;
        step_q <= '0;
      end
      else if (initiate_from_request)
      begin
        cur_q <= req;
        addr_q <= wrapped_addr;
        upper_q <= upper_stack;
        oor_q <= out_of_range_address;
        memory_busy_flag <= 1'b1;
        step_q <= '0;
        if (req.write)
        begin
          data_q <= req.data;
          par_q <= wr_gen;
        end
      end
      else if (busy)
      begin
        step_q <= step_q + 5'h01;
        // sensed word goes back unchanged, error or not
        if (!cur_q.write && step_q == CMPG_CHECK_TIME)
        begin
          data_q <= sense_data;
          par_q <= parity_bit_select;
        end
        if (step_q == CMPG_LAST_TIME)
          memory_busy_flag <= 1'b0;
      end
      else
        initialize_flag <= 1'b0;
    end
  end

  // error flags: setting wins over clearing
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      perr_q <= 1'b0;
      lamp_q <= 1'b0;
      halt_q <= 1'b0;
      chan_lamp_q <= '0;
      user_err_q <= '0;
      tx_err_q <= '0;
    end
    else if (clk_en)
    begin
      if (check_now && rd_err)
        perr_q <= 1'b1;
      else if (clr_main)
        perr_q <= 1'b0;
      if (check_now && rd_err)
        lamp_q <= 1'b1;
      else if (clr_lamp)
        lamp_q <= 1'b0;
      if (check_now && rd_err && temp_bad)
        halt_q <= 1'b1;
      else if (clr_lamp)
        halt_q <= 1'b0;
      if (check_now && rd_err && cur_q.user != CMPG_USER_CPU)
      begin
        chan_lamp_q <= chan_lamp_q | cur_user_onehot;
        user_err_q <= user_err_q | cur_user_onehot;
      end
      else if (clr_main)
        user_err_q <= '0;
      if (tx_err_now)
      begin
        tx_err_q <= tx_err_q | req_user_onehot;
        chan_lamp_q <= chan_lamp_q | req_user_onehot;
      end
      else if (clr_lamp)
      begin
        tx_err_q <= '0;
        if (!(check_now && rd_err))
          chan_lamp_q <= '0;
      end
    end
  end

  assign parity_error_flag = perr_q;
  assign console_parity_lamp_flag = lamp_q;
  assign core_parity_lamp = lamp_q;
  assign core_temp_lamp = temp_bad;
  assign alarm_lamp = lamp_q | temp_bad;
  assign external_alarm = alarm_option & (perr_q | temp_bad);
  assign no_parity_error = ~perr_q;
  assign cpu_access_blocked = perr_q & stop_sw;
  assign memory_halted = halt_q;
  assign channel_error_lamp = chan_lamp_q;
  assign user_parity_error_out = user_err_q;
  assign transmission_parity_error = tx_err_q;
  assign mem_addr = addr_q;
  assign write_data = data_q;
  assign write_parity = par_q;
  assign read_data = data_q;
  // read drive up to the check step, write drive after it, so the word is sensed before restore
  wire logic write_half = (step_q > CMPG_CHECK_TIME);
  assign drive.upper_read = busy & upper_q & ~write_half & mon_c;
  assign drive.upper_write = busy & upper_q & write_half & mon_c;
  assign drive.lower_read = busy & ~upper_q & ~write_half & mon_c;
  assign drive.lower_write = busy & ~upper_q & write_half & mon_c;

  a_flag_after_check: assert property (@(posedge core_clk) disable iff (!rstn)
    clk_en && check_now && rd_err |=> parity_error_flag)
    else $error("parity error not flagged after check");
  a_lamp_holds_jump: assert property (@(posedge core_clk) disable iff (!rstn)
    clk_en && lamp_q && !clr_lamp |=> lamp_q)
    else $error("console lamp cleared without alarm clear");
  a_no_start_monitor: assert property (@(posedge core_clk) disable iff (!rstn)
    req_accept |-> mon_a && mon_b && mon_c)
    else $error("cycle started with monitor low");
  a_drive_off_c: assert property (@(posedge core_clk) disable iff (!rstn)
    !mon_c |-> drive == '0)
    else $error("drive enabled with third monitor low");
  a_init_on_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clk_en && !mon_a |=> !memory_busy_flag && initialize_flag)
    else $error("first monitor low did not initialize");
  a_write_parity_gen: assert property (@(posedge core_clk) disable iff (!rstn)
    clk_en && mon_a && req_accept && req.write |=> write_parity == ~(^write_data))
    else $error("stored parity not generated");
  a_cpu_blocked: assert property (@(posedge core_clk) disable iff (!rstn)
    req_accept && is_cpu |-> !(perr_q && stop_sw))
    else $error("processor access while stopped on parity");
  a_chan_disable: assert property (@(posedge core_clk) disable iff (!rstn)
    req_accept |-> is_cpu || !cfg_q.no_channel_req)
    else $error("channel request taken while disabled");
  a_restore_sensed: assert property (@(posedge core_clk) disable iff (!rstn)
    clk_en && check_now |=> write_data == $past(sense_data))
    else $error("sensed word not kept for restore");
endmodule : cmpg_core_memory_parity_guard
`default_nettype wire

/* testbench/cmpg_stack_model.sv */
// Purpose: core stack model answering reads and taking writes
// Assumes: one word per address, unwritten words read as zero
// Notes: sense lines float between cycles, so idle output toggles
`default_nettype none
module cmpg_stack_model
  import cmpg_pkg::*;
(
  input wire logic core_clk,
  input wire logic [CMPG_ADDR_W-1:0] mem_addr,
  input wire logic [CMPG_DATA_W-1:0] write_data,
  input wire logic write_parity,
  input wire cmpg_drive_type drive,
  input wire logic busy,
  input wire logic flip_bit,
  output logic [CMPG_DATA_W-1:0] sense_data,
  output logic sense_parity_lower,
  output logic sense_parity_upper
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [CMPG_DATA_W:0] cells [int];
  logic [CMPG_DATA_W:0] word;
  always @(posedge core_clk)
  begin
    // stored word only changes under write drive
    if (drive.upper_write || drive.lower_write)
      cells[int'(mem_addr)] = {write_parity, write_data};
    word = cells.exists(int'(mem_addr)) ? cells[int'(mem_addr)] : '0;
    if (!busy)
      word = ~{sense_parity_lower, sense_data};
    sense_data <= word[CMPG_DATA_W-1:0] ^ {{(CMPG_DATA_W-1){1'b0}}, flip_bit};
    sense_parity_lower <= word[CMPG_DATA_W];
    sense_parity_upper <= word[CMPG_DATA_W];
  end
endmodule : cmpg_stack_model
`default_nettype wire

/* testbench/cmpg_core_memory_parity_guard_tb_top.sv */
// Purpose: self-checking bench for the parity guard
// Assumes: stack model on the core side, bench drives all pins
// Notes: pins synced by 2 flops, so waits of 3 cycles follow pin changes
`default_nettype none
module cmpg_core_memory_parity_guard_tb_top
  import cmpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rstn = 0, clk_en = 1, jump_if_no_parity = 0, clear_alarm = 0;
  logic initialize = 0, stop_on_parity = 0, alarm_option = 1, temp_out_of_range_pin = 0;
  logic power_loss_init_signal = 1, power_loss_start_block_signal = 1;
  logic power_loss_drive_block_signal = 1, flip_bit = 0;
  cmpg_cfg_type cfg_pins = '{CMPG_MEM_32K, 1'b0, 1'b0};
  cmpg_req_type req = '0;
  logic [CMPG_DATA_W-1:0] sense_data, write_data, read_data;
  logic sense_parity_lower, sense_parity_upper, req_accept, parity_error_flag;
  logic console_parity_lamp_flag, core_parity_lamp, core_temp_lamp, alarm_lamp;
  logic external_alarm, no_parity_error, cpu_access_blocked, memory_halted;
  logic cycle_initiate_flag, memory_busy_flag, initialize_flag, write_parity;
  logic [CMPG_USERS-1:0] channel_error_lamp, user_parity_error_out, transmission_parity_error;
  logic [CMPG_ADDR_W-1:0] mem_addr;
  cmpg_drive_type drive;
  int n_mismatch = 0, compares = 0, cycles = 0;
  int ref_mem [int];
  logic [31:0] seed = 32'h6A8187AF;
  always #5 core_clk = ~core_clk;
  cmpg_core_memory_parity_guard uut (.*);
  cmpg_stack_model stack (.core_clk(core_clk), .mem_addr(mem_addr), .write_data(write_data),
    .write_parity(write_parity), .drive(drive), .busy(memory_busy_flag), .flip_bit(flip_bit),
    .sense_data(sense_data), .sense_parity_lower(sense_parity_lower),
    .sense_parity_upper(sense_parity_upper));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic final_report;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // hang guard, well above the roughly one thousand cycles the run needs
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge core_clk);
    s = 0;
    @(negedge core_clk);
  endtask : pulse
  task automatic settle;
    repeat (3) @(negedge core_clk);
  endtask : settle
  // request held from a falling edge until the edge that takes it
  task automatic access(input logic wr, input logic [1:0] u, input int a,
                        input logic [23:0] d, input logic up, output logic ok);
    int n;
    req = '{1'b1, wr, u, a[14:0], d, up};
    ok = 0;
    for (n = 0; n < 8 && !ok; n++)
    begin
      #1 ok = req_accept;
      @(negedge core_clk);
    end
    req.valid = 0;
    if (ok)
    begin
      check(cycle_initiate_flag, 1);
      if (wr)
        check({write_data, write_parity}, {d, ~^d});
      for (n = 0; n < 40 && memory_busy_flag !== 1'b0; n++)
        @(negedge core_clk);
      check(memory_busy_flag, 0);
      @(negedge core_clk);
    end
  endtask : access
  task automatic wr(input int a, input logic [23:0] d, input logic [1:0] u, input logic up);
    logic ok;
    access(1, u, a, d, up, ok);
    check(ok, 1);
    ref_mem[a] = d;
  endtask : wr
  task automatic rd(input int a, input logic [1:0] u, input logic flip, input logic err);
    logic ok;
    flip_bit = flip;
    access(0, u, a, 24'h0, 1'b0, ok);
    flip_bit = 0;
    check(ok, 1);
    if (!ref_mem.exists(a))
      ref_mem[a] = 0;
    ref_mem[a] ^= flip;
    check(read_data, ref_mem[a]);
    check(parity_error_flag, err);
  endtask : rd
  initial
  begin
    logic ok;
    int i;
    int a;
    repeat (12) @(negedge core_clk);
    check({initialize_flag, no_parity_error, parity_error_flag}, 3'h6);
    rstn = 1;
    repeat (6) @(negedge core_clk);
    for (i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      a = {i[0], 1'b0, seed[12:0]};
      wr(a, seed[31:8], seed[1:0], ~^seed[31:8]);
      rd(a, seed[3:2], 0, 0);
      check(transmission_parity_error, 0);
    end
    rd(a, 0, 1, 1);
    check({console_parity_lamp_flag, core_parity_lamp, alarm_lamp}, 3'h7);
    check({external_alarm, no_parity_error}, 2'h2);
    pulse(jump_if_no_parity);
    check({parity_error_flag, console_parity_lamp_flag}, 2'h1);
    rd(a, 2, 0, 1);
    check({user_parity_error_out[2], channel_error_lamp[2]}, 2'h3);
    stop_on_parity = 1;
    settle();
    access(0, 0, a, 24'h0, 1'b0, ok);
    check({ok, cpu_access_blocked}, 2'h1);
    pulse(clear_alarm);
    check({parity_error_flag, console_parity_lamp_flag}, 2'h0);
    stop_on_parity = 0;
    wr(5, 24'h000007, 1, 1'b1);
    check({transmission_parity_error, channel_error_lamp[1]}, 5'h5);
    rd(5, 0, 0, 0);
    pulse(initialize);
    check(transmission_parity_error, 0);
    // options reach the guard only at the next idle edge
    cfg_pins.size = CMPG_MEM_24K;
    @(negedge core_clk);
    rd(32'h7000, 0, 0, 0);
    cfg_pins.size = CMPG_MEM_32K;
    @(negedge core_clk);
    rd(32'h7001, 0, 0, 1);
    pulse(clear_alarm);
    cfg_pins.no_channel_req = 1;
    @(negedge core_clk);
    access(0, 1, 5, 24'h0, 1'b0, ok);
    check(ok, 0);
    cfg_pins.no_channel_req = 0;
    power_loss_start_block_signal = 0;
    settle();
    access(0, 0, 5, 24'h0, 1'b0, ok);
    check(ok, 0);
    power_loss_start_block_signal = 1;
    settle();
    fork
      wr(9, 24'h0000AA, 0, 1'b1);
      begin
        repeat (4) @(negedge core_clk);
        power_loss_drive_block_signal = 0;
        repeat (6) @(negedge core_clk);
        check(drive, 0);
        power_loss_drive_block_signal = 1;
      end
    join
    power_loss_init_signal = 0;
    settle();
    check({initialize_flag, memory_busy_flag, cycle_initiate_flag}, 3'h4);
    access(0, 0, 5, 24'h0, 1'b0, ok);
    check(ok, 0);
    power_loss_init_signal = 1;
    repeat (6) @(negedge core_clk);
    temp_out_of_range_pin = 1;
    settle();
    check({core_temp_lamp, alarm_lamp, memory_halted}, 3'h6);
    rd(5, 0, 1, 1);
    check(memory_halted, 1);
    access(0, 1, 5, 24'h0, 1'b0, ok);
    check(ok, 0);
    temp_out_of_range_pin = 0;
    pulse(clear_alarm);
    check(memory_halted, 0);
    // monitor keeps drive enable high after start block drops, so the write completes
    fork
      wr(11, 24'h00000F, 0, 1'b1);
      begin
        repeat (4) @(negedge core_clk);
        power_loss_start_block_signal = 0;
        repeat (20) @(negedge core_clk);
        power_loss_start_block_signal = 1;
      end
    join
    settle();
    cfg_pins.swap_stacks = 1;
    @(negedge core_clk);
    fork
      rd(11, 0, 0, 0);
      begin
        repeat (3) @(negedge core_clk);
        check(drive, 4'h8);
      end
    join
    cfg_pins.swap_stacks = 0;
    final_report();
  end
endmodule : cmpg_core_memory_parity_guard_tb_top
`default_nettype wire
